// ===== bench/pmw_mode_chk.sv
`timescale 1ns/1ps
// Watches clock steering and the halt and wake handshake of the controller.
module pmw_mode_chk
   import pmw_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Core events.
   input wire logic halt_i,
   input wire logic wdt_overflow_i,
   // Watched outputs.
   input wire pmw_clk_en_type clk_en_o,
   input wire logic sysclk_low_sel_o,
   input wire logic cpu_hold_o,
   input wire logic wdt_clear_o,
   input wire logic wdt_stop_o,
   input wire logic full_reset_o,
   input wire logic wdt_reset_o,
   input wire logic resume_next_o,
   input wire logic irq_take_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // A wake pulse of any kind, and the cycle in which the hold drops.
   sequence s_any_wake;
      resume_next_o || irq_take_o || wdt_reset_o || full_reset_o;
   endsequence
   sequence s_left_hold;
      $fell(cpu_hold_o) && $past(reset_n_i);
   endsequence
   property p_entry;
      $rose(cpu_hold_o) |-> $past(halt_i) && wdt_clear_o;
   endproperty
   a_entry: assert property (p_entry) else $error("hold rose without halt");
   property p_clear_once;
      wdt_clear_o |-> $rose(cpu_hold_o);
   endproperty
   a_clear_once: assert property (p_clear_once) else $error("stray clear");
   property p_all_stop;
      wdt_stop_o |-> cpu_hold_o && !clk_en_o.sys && !clk_en_o.wdt && !clk_en_o.tbase;
   endproperty
   a_all_stop: assert property (p_all_stop) else $error("clock left on");
   property p_fast_off;
      $rose(sysclk_low_sel_o) |-> !clk_en_o.hosc && !clk_en_o.hdiv;
   endproperty
   a_fast_off: assert property (p_fast_off) else $error("fast clock kept");
   property p_wake;
      s_left_hold |-> s_any_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without cause");
   property p_resume;
      resume_next_o || irq_take_o || wdt_reset_o |-> $fell(cpu_hold_o);
   endproperty
   a_resume: assert property (p_resume) else $error("pulse outside wake");
   property p_wdt_wake;
      cpu_hold_o && wdt_overflow_i |=> wdt_reset_o || full_reset_o;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("overflow ignored");
   property p_refuse;
      cpu_hold_o && halt_i |=> !wdt_clear_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("halt taken twice");
endmodule : pmw_mode_chk

bind pmw_mode_ctrl pmw_mode_chk i_chk (
   .mclk_i, .reset_n_i, .halt_i, .wdt_overflow_i, .clk_en_o,
   .sysclk_low_sel_o, .cpu_hold_o, .wdt_clear_o, .wdt_stop_o,
   .full_reset_o, .wdt_reset_o, .resume_next_o, .irq_take_o
);

// ===== bench/pmw_mode_ctrl_tb_top.sv
`timescale 1ns/1ps
// Scenario bench for the mode controller.
module pmw_mode_ctrl_tb_top;
   import pmw_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   pmw_apb_req_type apb_req_i = '0;
   pmw_apb_rsp_type apb_rsp_o;
   logic halt_i = 1'b0;
   logic clr_wdt_i = 1'b0;
   logic wdt_enable_i = 1'b0;
   logic lvd_enable_i = 1'b0;
   logic wdt_overflow_i = 1'b0;
   logic [IRQ_W-1:0] irq_req_i = '0;
   logic [IRQ_W-1:0] irq_enable_i = '0;
   logic stack_full_i = 1'b0;
   logic ext_reset_n_i = 1'b1;
   logic [PORTA_W-1:0] porta_i = 8'hFF;
   logic low_osc_stable_i;
   logic high_osc_stable_i;
   pmw_clk_en_type clk_en_o;
   logic sysclk_low_sel_o;
   logic cpu_hold_o;
   logic wdt_clear_o;
   logic wdt_stop_o;
   logic full_reset_o;
   logic wdt_reset_o;
   logic resume_next_o;
   logic irq_take_o;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic rerr;
   // 200 MHz clock.
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   // Design and oscillator model.
   pmw_mode_ctrl i_dut (
      .mclk_i, .reset_n_i, .apb_req_i, .apb_rsp_o, .halt_i, .clr_wdt_i,
      .wdt_enable_i, .lvd_enable_i, .wdt_overflow_i, .irq_req_i, .irq_enable_i,
      .stack_full_i, .ext_reset_n_i, .porta_i, .low_osc_stable_i,
      .high_osc_stable_i, .clk_en_o, .sysclk_low_sel_o, .cpu_hold_o,
      .wdt_clear_o, .wdt_stop_o, .full_reset_o, .wdt_reset_o,
      .resume_next_o, .irq_take_o
   );
   pmw_osc_model i_osc (
      .mclk_i, .hosc_en_i(clk_en_o.hosc), .low_osc_stable_o(low_osc_stable_i),
      .high_osc_stable_o(high_osc_stable_i)
   );
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge mclk_i);
      apb_req_i.psel <= 1'b1;
      apb_req_i.pwrite <= wr;
      apb_req_i.paddr <= addr;
      apb_req_i.pwdata <= wd;
      @(posedge mclk_i);
      apb_req_i.penable <= 1'b1;
      do begin
         @(posedge mclk_i);
      end while (apb_rsp_o.pready !== 1'b1);
      rd = apb_rsp_o.prdata;
      rerr = apb_rsp_o.pslverr;
      apb_req_i.psel <= 1'b0;
      apb_req_i.penable <= 1'b0;
   endtask : bus
   // Reads a register and compares data and error response.
   task automatic rdchk(input string what, input logic [7:0] addr,
                        input logic [31:0] exp, input logic err);
      bus(1'b0, addr, 32'h0);
      chk(what, exp, rd);
      chk("pslverr", {31'h0, err}, {31'h0, rerr});
   endtask : rdchk
   // One-cycle halt, settling at the next falling edge.
   task automatic do_halt();
      @(posedge mclk_i);
      halt_i <= 1'b1;
      @(posedge mclk_i);
      halt_i <= 1'b0;
      @(negedge mclk_i);
   endtask : do_halt
   // Bounded wait for the hold to drop; wake pulses are then visible.
   task automatic wait_wake();
      for (int n = 0; n < 40 && cpu_hold_o === 1'b1; n++) @(negedge mclk_i);
   endtask : wait_wake
   // Reset values, write masks, read-only status and an unmapped address.
   task automatic t_regs();
      rdchk("mode", MODE_ADDR, 32'h0000000D, 1'b0);
      rdchk("status", STAT_ADDR, 32'h0, 1'b0);
      rdchk("wake", WAKE_ADDR, 32'h0, 1'b0);
      rdchk("hole", 8'h10, 32'h0, 1'b1);
      rdchk("mode2", MODE2_ADDR, 32'h0, 1'b0);
      bus(1'b1, MODE2_ADDR, 32'hFFFFFFFF);
      rdchk("mode2", MODE2_ADDR, 32'h00000080, 1'b0);
      bus(1'b1, STAT_ADDR, 32'hFF);
      rdchk("status", STAT_ADDR, 32'h0, 1'b0);
      bus(1'b1, MODE2_ADDR, 32'h0);
   endtask : t_regs
   // Source and divider codes across both clock modes.
   task automatic t_slow();
      logic [31:0] code [4] = '{32'h20, 32'h21, 32'h00, 32'hE0};
      logic slow [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, MODE_ADDR, code[i]);
         for (int n = 0; n < 40 && sysclk_low_sel_o !== slow[i]; n++) @(negedge mclk_i);
         chk("slow select", {31'h0, slow[i]}, {31'h0, sysclk_low_sel_o});
         chk("fast clocks", {30'h0, {2{!slow[i]}}}, {30'h0, clk_en_o.hosc, clk_en_o.hdiv});
      end
      rdchk("mode", MODE_ADDR, 32'h000000E8, 1'b0);
      repeat (16) @(posedge mclk_i);
      rdchk("mode", MODE_ADDR, 32'h000000EC, 1'b0);
      bus(1'b1, MODE_ADDR, 32'h1);
   endtask : t_slow
   // Each low-power state, woken by its enabled port pin only.
   task automatic t_sleep();
      logic [3:0] cfg [4] = '{4'h0, 4'h1, 4'h8, 4'hC};
      logic [2:0] st [4] = '{PWR_CODE_S0, PWR_CODE_S1, PWR_CODE_I0, PWR_CODE_I1};
      logic [2:0] clk [4] = '{3'h4, 3'h0, 3'h1, 3'h3};
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, MODE_ADDR, {30'h0, cfg[i][3], 1'b1});
         bus(1'b1, MODE2_ADDR, {24'h0, cfg[i][2], 7'h0});
         bus(1'b1, WAKE_ADDR, 32'h1 << i);
         lvd_enable_i <= cfg[i][0];
         do_halt();
         chk("entry", 32'h3, {30'h0, cpu_hold_o, wdt_clear_o});
         chk("clocks", {29'h0, clk[i]}, {29'h0, wdt_stop_o, clk_en_o.sys, clk_en_o.tbase});
         if (i < 2) chk("wdt clock", i, {31'h0, clk_en_o.wdt});
         rdchk("status", STAT_ADDR, {25'h0, st[i], 4'h1}, 1'b0);
         porta_i[7] <= 1'b0;
         repeat (8) @(posedge mclk_i);
         chk("masked pin", 32'h1, {31'h0, cpu_hold_o});
         porta_i[i] <= 1'b0;
         wait_wake();
         chk("pin wake", 32'h1, {31'h0, resume_next_o});
         @(posedge mclk_i);
         porta_i <= 8'hFF;
      end
      bus(1'b1, WAKE_ADDR, 32'h0);
      lvd_enable_i <= 1'b0;
   endtask : t_sleep
   // Watchdog overflow in sleep, then the clear instruction.
   task automatic t_wdt();
      bus(1'b1, MODE_ADDR, 32'h1);
      wdt_enable_i <= 1'b1;
      do_halt();
      @(posedge mclk_i);
      wdt_overflow_i <= 1'b1;
      @(posedge mclk_i);
      wdt_overflow_i <= 1'b0;
      wait_wake();
      chk("wdt wake", 32'h2, {30'h0, wdt_reset_o, full_reset_o});
      rdchk("status", STAT_ADDR, 32'h3, 1'b0);
      clr_wdt_i <= 1'b1;
      @(posedge mclk_i);
      clr_wdt_i <= 1'b0;
      bus(1'b0, STAT_ADDR, 32'h0);
      chk("pdf", 32'h0, {31'h0, rd[STAT_PDF_BIT]});
      wdt_overflow_i <= 1'b1;
      @(posedge mclk_i);
      wdt_overflow_i <= 1'b0;
      @(negedge mclk_i);
      chk("run overflow", 32'h1, {30'h0, wdt_reset_o, full_reset_o});
      @(posedge mclk_i);
      wdt_enable_i <= 1'b0;
   endtask : t_wdt
   // Stale request, serviced, disabled and stack-full interrupt wakes.
   task automatic t_irq();
      logic [3:0] en [3] = '{4'hF, 4'hB, 4'hF};
      logic full [3] = '{1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 3; i++) begin
         irq_enable_i <= en[i];
         stack_full_i <= full[i];
         irq_req_i <= 4'h1;
         do_halt();
         repeat (8) @(posedge mclk_i);
         chk("stale irq", 32'h1, {31'h0, cpu_hold_o});
         irq_req_i[2] <= 1'b1;
         wait_wake();
         chk("irq wake", (i == 0) ? 32'h2 : 32'h1, {30'h0, irq_take_o, resume_next_o});
         @(posedge mclk_i);
         irq_req_i <= 4'h0;
         @(posedge mclk_i);
      end
      stack_full_i <= 1'b0;
   endtask : t_irq
   // External reset wake, after a second halt that must be refused.
   task automatic t_ext();
      do_halt();
      do_halt();
      chk("held", 32'h1, {31'h0, cpu_hold_o});
      @(posedge mclk_i);
      ext_reset_n_i <= 1'b0;
      wait_wake();
      chk("reset wake", 32'h1, {31'h0, full_reset_o});
      @(posedge mclk_i);
      ext_reset_n_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
   endtask : t_ext
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // Reset, then the scenarios in turn.
   initial begin
      repeat (12) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      // No reset pulse may follow the release while the pin idles high.
      for (int n = 0; n < 4; n++) begin
         @(negedge mclk_i);
         chk("idle reset pulse", 32'h0, {31'h0, full_reset_o});
      end
      t_regs();
      t_slow();
      t_sleep();
      t_wdt();
      t_irq();
      t_ext();
      complete_run();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_total++;
      complete_run();
   end
endmodule : pmw_mode_ctrl_tb_top

// ===== bench/pmw_osc_model.sv
`timescale 1ns/1ps
// Oscillator pair on the far side; both settle late so the waits are real.
module pmw_osc_model #(
   parameter int LOW_START = 6,
   parameter int HIGH_START = 9
) (
   // Clock and fast oscillator enable.
   input wire logic mclk_i,
   input wire logic hosc_en_i,
   // Stability levels.
   output logic low_osc_stable_o,
   output logic high_osc_stable_o
);
   int low_cnt = 0;
   int high_cnt = 0;
   // The slow one settles once; the fast one restarts whenever it is stopped.
   always @(posedge mclk_i) begin
      if (low_cnt < LOW_START) low_cnt <= low_cnt + 1;
      if (!hosc_en_i) high_cnt <= 0;
      else if (high_cnt < HIGH_START) high_cnt <= high_cnt + 1;
   end
   assign low_osc_stable_o = (low_cnt >= LOW_START);
   assign high_osc_stable_o = hosc_en_i && (high_cnt >= HIGH_START);
endmodule : pmw_osc_model

// ===== logic/pmw_fall_detect.sv
`timescale 1ns/1ps
// Per-pin falling edge detector on already synchronised inputs, gated by an enable.
module pmw_fall_detect #(
   parameter int W = 8
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] level_i,
   input wire logic [W-1:0] enable_i,
   output logic any_fall_o
);
   logic [W-1:0] prev_q;
   logic [W-1:0] prev_d;
   logic [W-1:0] fall;

   // Each pin has its own edge term.
   for (genvar i = 0; i < W; i++) begin : g_pin
      assign fall[i] = prev_q[i] & ~level_i[i] & enable_i[i];
   end

   always_comb begin
      prev_d = level_i;
   end

   // Previous level starts high, so a pin already low after reset counts as an edge.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         prev_q <= '1;
      end else begin
         prev_q <= prev_d;
      end
   end

   assign any_fall_o = |fall;
endmodule : pmw_fall_detect

// ===== logic/pmw_mode_ctrl.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Operating mode controller: clock source switching, halt states and wake-up.
module pmw_mode_ctrl
   import pmw_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Register bus.
   input wire pmw_apb_req_type apb_req_i,
   output pmw_apb_rsp_type apb_rsp_o,
   // Core events, same clock.
   input wire logic halt_i,
   input wire logic clr_wdt_i,
   input wire logic wdt_enable_i,
   input wire logic lvd_enable_i,
   input wire logic wdt_overflow_i,
   input wire logic [IRQ_W-1:0] irq_req_i,
   input wire logic [IRQ_W-1:0] irq_enable_i,
   input wire logic stack_full_i,
   // Pins and oscillators, asynchronous.
   input wire logic ext_reset_n_i,
   input wire logic [PORTA_W-1:0] porta_i,
   input wire logic low_osc_stable_i,
   input wire logic high_osc_stable_i,
   // Clock steering.
   output pmw_clk_en_type clk_en_o,
   output logic sysclk_low_sel_o,
   // Core control.
   output logic cpu_hold_o,
   output logic wdt_clear_o,
   output logic wdt_stop_o,
   output logic full_reset_o,
   output logic wdt_reset_o,
   output logic resume_next_o,
   output logic irq_take_o
);
   pmw_clk_type clk_q, clk_d;
   pmw_pwr_type pwr_q, pwr_d;
   logic hsel_q, hsel_d;
   logic [2:0] div_q, div_d;
   logic idle_q, idle_d;
   logic syson_q, syson_d;
   logic [PORTA_W-1:0] wake_en_q, wake_en_d;
   logic pdf_q, pdf_d;
   logic to_q, to_d;
   logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
   logic wdt_clear_q, wdt_clear_d;
   logic full_reset_q, full_reset_d;
   logic wdt_reset_q, wdt_reset_d;
   logic resume_q, resume_d;
   logic irq_take_q, irq_take_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0] sync_misc;
   logic [PORTA_W-1:0] porta_s, porta_low_s;
   logic lo_rdy, hi_rdy, ext_rst_s;
   logic port_wake, irq_wake, ext_wake, want_slow;
   logic [IRQ_W-1:0] irq_new;
   logic [2:0] pwr_code;
   logic wr_en, rd_setup, mapped;

   // Pins and oscillator ready levels pass two flops before use.
   // Idle-high pins are inverted first, so a stage held in reset reads as an idle pin.
   pmw_sync #(.W(3)) u_sync_misc (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .async_i({~ext_reset_n_i, high_osc_stable_i, low_osc_stable_i}),
      .sync_o(sync_misc)
   );
   pmw_sync #(.W(PORTA_W)) u_sync_porta (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .async_i(~porta_i),
      .sync_o(porta_low_s)
   );
   assign lo_rdy = sync_misc[0];
   assign hi_rdy = sync_misc[1];
   assign ext_rst_s = sync_misc[2];
   assign porta_s = ~porta_low_s;

   // Falling edges on enabled port pins.
   pmw_fall_detect #(.W(PORTA_W)) u_fall (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .level_i(porta_s),
      .enable_i(wake_en_q),
      .any_fall_o(port_wake)
   );

   // Wake sources; requests already pending at entry are masked off.
   always_comb begin
      want_slow = !hsel_q && (div_q <= DIV_SLOW_MAX);
      irq_new = irq_req_i & ~irq_mask_q;
      irq_wake = |irq_new;
      ext_wake = ext_rst_s;
   end

   // Register bus decode; write strobe in the access phase, read capture in setup.
   always_comb begin
      mapped = (apb_req_i.paddr == MODE_ADDR) || (apb_req_i.paddr == MODE2_ADDR)
         || (apb_req_i.paddr == STAT_ADDR) || (apb_req_i.paddr == WAKE_ADDR);
      wr_en = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && mapped;
      rd_setup = apb_req_i.psel && !apb_req_i.penable;
   end

   // Power state code for the status register.
   always_comb begin
      case (pwr_q)
         PWR_SLEEP_ALL_STOPPED: pwr_code = PWR_CODE_S0;
         PWR_SLEEP_LOW_SPEED_INTERNAL_OSC_ALIVE: pwr_code = PWR_CODE_S1;
         PWR_IDLE_TIMEBASE_ONLY: pwr_code = PWR_CODE_I0;
         PWR_IDLE_CLOCKS_RUNNING: pwr_code = PWR_CODE_I1;
         default: pwr_code = PWR_CODE_RUN;
      endcase
   end

   // Software registers and read data.
   always_comb begin
      hsel_d = hsel_q;
      div_d = div_q;
      idle_d = idle_q;
      syson_d = syson_q;
      wake_en_d = wake_en_q;
      rdata_d = rdata_q;
      if (wr_en && apb_req_i.paddr == MODE_ADDR) begin
         hsel_d = apb_req_i.pwdata[MODE_HSEL_BIT];
         idle_d = apb_req_i.pwdata[MODE_IDLE_BIT];
         div_d = apb_req_i.pwdata[MODE_DIV_LSB +: 3];
      end else if (wr_en && apb_req_i.paddr == MODE2_ADDR) begin
         syson_d = apb_req_i.pwdata[MODE2_SYSON_BIT];
      end else if (wr_en && apb_req_i.paddr == WAKE_ADDR) begin
         wake_en_d = apb_req_i.pwdata[PORTA_W-1:0];
      end
      if (rd_setup) begin
         rdata_d = 32'h0000_0000;
         if (apb_req_i.paddr == MODE_ADDR) begin
            rdata_d[MODE_HSEL_BIT] = hsel_q;
            rdata_d[MODE_IDLE_BIT] = idle_q;
            rdata_d[MODE_HRDY_BIT] = hi_rdy && clk_en_o.hosc;
            rdata_d[MODE_LRDY_BIT] = lo_rdy;
            rdata_d[MODE_DIV_LSB +: 3] = div_q;
         end else if (apb_req_i.paddr == MODE2_ADDR) begin
            rdata_d[MODE2_SYSON_BIT] = syson_q;
         end else if (apb_req_i.paddr == STAT_ADDR) begin
            rdata_d[STAT_PDF_BIT] = pdf_q;
            rdata_d[STAT_TO_BIT] = to_q;
            rdata_d[STAT_PWR_LSB +: 3] = pwr_code;
         end else if (apb_req_i.paddr == WAKE_ADDR) begin
            rdata_d[PORTA_W-1:0] = wake_en_q;
         end
      end
   end

   // Clock source switching between fast and slow.
   always_comb begin
      clk_d = clk_q;
      case (clk_q)
         CLK_NORMAL: begin
            if (want_slow) begin
               clk_d = CLK_TO_SLOW;
            end
         end
         CLK_TO_SLOW: begin
            if (!want_slow) begin
               clk_d = CLK_NORMAL;
            end else if (lo_rdy) begin
               clk_d = CLK_SLOW;
            end
         end
         CLK_SLOW: begin
            if (!want_slow) begin
               clk_d = CLK_TO_NORMAL;
            end
         end
         default: begin
            if (want_slow) begin
               clk_d = CLK_SLOW;
            end else if (hi_rdy) begin
               clk_d = CLK_NORMAL;
            end
         end
      endcase
   end

   // Halt entry, wake-up and status flags; a setting event beats a clear.
   always_comb begin
      pwr_d = pwr_q;
      pdf_d = pdf_q;
      to_d = to_q;
      irq_mask_d = irq_mask_q;
      wdt_clear_d = 1'b0;
      full_reset_d = 1'b0;
      wdt_reset_d = 1'b0;
      resume_d = 1'b0;
      irq_take_d = 1'b0;
      if (clr_wdt_i) begin
         pdf_d = 1'b0;
      end
      if (ext_wake) begin
         pwr_d = PWR_RUN;
         full_reset_d = 1'b1;
      end else if (pwr_q == PWR_RUN) begin
         if (wdt_overflow_i) begin
            to_d = 1'b1;
            full_reset_d = 1'b1;
         end else if (halt_i) begin
            pdf_d = 1'b1;
            to_d = 1'b0;
            wdt_clear_d = 1'b1;
            irq_mask_d = irq_req_i;
            if (idle_q && syson_q) begin
               pwr_d = PWR_IDLE_CLOCKS_RUNNING;
            end else if (idle_q) begin
               pwr_d = PWR_IDLE_TIMEBASE_ONLY;
            end else if (wdt_enable_i || lvd_enable_i) begin
               pwr_d = PWR_SLEEP_LOW_SPEED_INTERNAL_OSC_ALIVE;
            end else begin
               pwr_d = PWR_SLEEP_ALL_STOPPED;
            end
         end
      end else if (wdt_overflow_i) begin
         pwr_d = PWR_RUN;
         to_d = 1'b1;
         wdt_reset_d = 1'b1;
      end else if (irq_wake) begin
         pwr_d = PWR_RUN;
         if (|(irq_new & irq_enable_i) && !stack_full_i) begin
            irq_take_d = 1'b1;
         end else begin
            resume_d = 1'b1;
         end
      end else if (port_wake) begin
         pwr_d = PWR_RUN;
         resume_d = 1'b1;
      end
   end

   // All state registers; power-up reset clears both flags.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         clk_q <= CLK_NORMAL;
         pwr_q <= PWR_RUN;
         hsel_q <= HSEL_RST;
         div_q <= DIV_RST;
         idle_q <= IDLE_RST;
         syson_q <= SYSON_RST;
         wake_en_q <= WAKE_RST;
         pdf_q <= 1'b0;
         to_q <= 1'b0;
         irq_mask_q <= '0;
         wdt_clear_q <= 1'b0;
         full_reset_q <= 1'b0;
         wdt_reset_q <= 1'b0;
         resume_q <= 1'b0;
         irq_take_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         clk_q <= clk_d;
         pwr_q <= pwr_d;
         hsel_q <= hsel_d;
         div_q <= div_d;
         idle_q <= idle_d;
         syson_q <= syson_d;
         wake_en_q <= wake_en_d;
         pdf_q <= pdf_d;
         to_q <= to_d;
         irq_mask_q <= irq_mask_d;
         wdt_clear_q <= wdt_clear_d;
         full_reset_q <= full_reset_d;
         wdt_reset_q <= wdt_reset_d;
         resume_q <= resume_d;
         irq_take_q <= irq_take_d;
         rdata_q <= rdata_d;
      end
   end

   // Clock enables follow the clock and power states.
   always_comb begin
      sysclk_low_sel_o = (clk_q == CLK_SLOW);
      clk_en_o.hosc = !sysclk_low_sel_o && (pwr_q != PWR_SLEEP_ALL_STOPPED)
         && (pwr_q != PWR_SLEEP_LOW_SPEED_INTERNAL_OSC_ALIVE);
      clk_en_o.hdiv = clk_en_o.hosc;
      clk_en_o.sys = (pwr_q == PWR_RUN) || (pwr_q == PWR_IDLE_CLOCKS_RUNNING);
      clk_en_o.tbase = clk_en_o.sys || (pwr_q == PWR_IDLE_TIMEBASE_ONLY);
      clk_en_o.wdt = (pwr_q != PWR_SLEEP_ALL_STOPPED);
      cpu_hold_o = (pwr_q != PWR_RUN);
      wdt_stop_o = (pwr_q == PWR_SLEEP_ALL_STOPPED);
   end

   assign wdt_clear_o = wdt_clear_q;
   assign full_reset_o = full_reset_q;
   assign wdt_reset_o = wdt_reset_q;
   assign resume_next_o = resume_q;
   assign irq_take_o = irq_take_q;

   // Zero-wait slave; unmapped addresses answer with an error.
   always_comb begin
      apb_rsp_o.prdata = rdata_q;
      apb_rsp_o.pready = 1'b1;
      apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && !mapped;
   end
endmodule : pmw_mode_ctrl

// ===== logic/pmw_pkg.sv
package pmw_pkg;
   localparam int PORTA_W = 8;
   localparam int IRQ_W = 4;
   localparam int ADDR_W = 8;
   // Register byte addresses.
   localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] MODE2_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] WAKE_ADDR = 8'h0C;
   // Field positions.
   localparam int MODE_HSEL_BIT = 0;
   localparam int MODE_IDLE_BIT = 1;
   localparam int MODE_HRDY_BIT = 2;
   localparam int MODE_LRDY_BIT = 3;
   localparam int MODE_DIV_LSB = 5;
   localparam int MODE2_SYSON_BIT = 7;
   localparam int STAT_PDF_BIT = 0;
   localparam int STAT_TO_BIT = 1;
   localparam int STAT_PWR_LSB = 4;
   // Reset values.
   localparam logic HSEL_RST = 1'b1;
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic IDLE_RST = 1'b0;
   localparam logic SYSON_RST = 1'b0;
   localparam logic [PORTA_W-1:0] WAKE_RST = 8'h00;
   // Highest divider code that still selects the slow clock.
   localparam logic [2:0] DIV_SLOW_MAX = 3'h1;
   // Power state codes shown in the status register.
   localparam logic [2:0] PWR_CODE_RUN = 3'h0;
   localparam logic [2:0] PWR_CODE_S0 = 3'h1;
   localparam logic [2:0] PWR_CODE_S1 = 3'h2;
   localparam logic [2:0] PWR_CODE_I0 = 3'h3;
   localparam logic [2:0] PWR_CODE_I1 = 3'h4;

   typedef enum logic [1:0] {
      CLK_NORMAL, CLK_TO_SLOW, CLK_SLOW, CLK_TO_NORMAL
   } pmw_clk_type;

   typedef enum logic [2:0] {
      PWR_RUN, PWR_SLEEP_ALL_STOPPED, PWR_SLEEP_LOW_SPEED_INTERNAL_OSC_ALIVE,
      PWR_IDLE_TIMEBASE_ONLY, PWR_IDLE_CLOCKS_RUNNING
   } pmw_pwr_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pmw_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pmw_apb_rsp_type;

   typedef struct packed {
      logic sys;
      logic wdt;
      logic tbase;
      logic hosc;
      logic hdiv;
   } pmw_clk_en_type;
endpackage : pmw_pkg

// ===== logic/pmw_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of independent level signals.
module pmw_sync #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // Next values: the first stage feeds only the second.
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   // Both stages reset low.
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule : pmw_sync
